// >>> hdl/clock_path_config.v
// Clock source path configuration: staged and active registers,
// update strobe, VCO calibration sequencer and nonvolatile settings store.
// Assumes the serial port pins are synchronous to sys_clk.
`timescale 1ns/1ps
`include "clock_path_config_regs.vh"
module clock_path_config
(
   input wire sys_clk,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire sdi,
   output reg sdo_ff_o,
   output reg sdo_oe_o,
   output reg pll_power_down_ff,
   output reg vco_source_ff,
   output reg div_bypass_ff,
   output reg [2:0] div_ratio_ff,
   output reg pd_negative_ff,
   output reg vco_power_on_ff,
   output reg ext_to_prescaler_ff,
   output reg [2:0] ref_enable_ff,
   output reg cal_busy_ff,
   output reg cal_done_ff
);
   localparam CAL_IDLE = 2'h0; // Waiting for a start
   localparam CAL_RUN = 2'h1; // Tuning range search running
   localparam CAL_DONE = 2'h2; // Finished until bit cleared
   localparam NV_IDLE = 2'h0; // Nothing to do
   localparam NV_LOAD = 2'h1; // Copying store into registers
   localparam NV_SAVE = 2'h2; // Copying active set into store
   localparam integer CAL_LAST_I = `CAL_CYCLES - 1; // Final count of a run
   // Cut to the counter width so the compare below has matching widths
   localparam [7:0] CAL_LAST = CAL_LAST_I[7:0];

   // Decode of the ratio field into the actual division factor
   function [2:0] ratio_of;
      input [2:0] code;
      begin
         case (code)
            3'h0: ratio_of = 3'h2;
            3'h1: ratio_of = 3'h3;
            3'h2: ratio_of = 3'h4;
            3'h3: ratio_of = 3'h5;
            3'h4: ratio_of = 3'h6;
            default: ratio_of = 3'h1;
         endcase
      end
   endfunction

   wire sp_sdo; // Serial data out from port
   wire sp_oe; // Serial data enable from port
   wire [12:0] sp_addr; // Decoded register address
   wire [7:0] sp_wdata; // Written byte
   wire sp_wr; // Write pulse
   reg [7:0] rdata; // Read mux

   // Staging copies; written by software, not yet in effect
   reg [7:0] stg_ff [0:4];
   // Active copies; drive the clock path
   reg [7:0] act_ff [0:4];
   // Nonvolatile store survives reset, so it is initialised, never reset
   reg [7:0] nv_mem [0:4];
   reg nv_valid = 1'b0; // Store has been written at least once
   reg [1:0] nv_st_ff; // Store sequencer state
   reg [2:0] nv_idx_ff; // Store word pointer
   reg [1:0] cal_st_ff; // Calibration state
   reg [7:0] cal_cnt_ff; // Calibration time counter
   reg cal_prev_ff; // Active calibration bit last cycle
   reg upd; // Update strobe this cycle
   integer i;

   initial
   begin
      for (i = 0; i < 5; i = i + 1)
         nv_mem[i] = 8'h00;
   end

   serial_port_slave u_port
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .rdata(rdata),
      .sdo_ff(sp_sdo),
      .sdo_oe_ff(sp_oe),
      .addr_ff(sp_addr),
      .wdata_ff(sp_wdata),
      .wr_ff(sp_wr)
   );

   // Index of a staged register, 7 when unmapped
   function [2:0] idx_of;
      input [12:0] a;
      begin
         case (a)
            `OFS_PWR_POL: idx_of = 3'h0;
            `OFS_VCO_CAL: idx_of = 3'h1;
            `OFS_REF_EN: idx_of = 3'h2;
            `OFS_DIV_RATIO: idx_of = 3'h3;
            `OFS_SRC_SEL: idx_of = 3'h4;
            default: idx_of = 3'h7;
         endcase
      end
   endfunction

   // Read mux: reads return the staged value so software sees its write
   always @*
   begin
      rdata = 8'h00;
      if (idx_of(sp_addr) != 3'h7)
         rdata = stg_ff[idx_of(sp_addr)];
      else if (sp_addr == `OFS_STATUS)
         rdata = {5'h00, nv_valid, cal_busy_ff, cal_done_ff};
      else if (sp_addr == `OFS_NV_CTRL)
         rdata = {7'h00, nv_st_ff != NV_IDLE};
   end

   // Update strobe is a self-clearing bit; it always reads zero
   always @*
   begin
      upd = sp_wr && sp_addr == `OFS_UPDATE && sp_wdata[`UPDATE_BIT];
   end

   // Staging, activation and nonvolatile store sequencing
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         stg_ff[0] <= `RST_PWR_POL;
         stg_ff[1] <= `RST_VCO_CAL;
         stg_ff[2] <= `RST_REF_EN;
         stg_ff[3] <= `RST_DIV_RATIO;
         stg_ff[4] <= `RST_SRC_SEL;
         act_ff[0] <= `RST_PWR_POL;
         act_ff[1] <= `RST_VCO_CAL;
         act_ff[2] <= `RST_REF_EN;
         act_ff[3] <= `RST_DIV_RATIO;
         act_ff[4] <= `RST_SRC_SEL;
         nv_st_ff <= NV_LOAD;
         nv_idx_ff <= 3'h0;
      end
      else
      begin
         case (nv_st_ff)
            NV_LOAD:
            begin
               // Restore stored settings with no software help
               if (nv_valid)
               begin
                  stg_ff[nv_idx_ff] <= nv_mem[nv_idx_ff];
                  act_ff[nv_idx_ff] <= nv_mem[nv_idx_ff];
               end
               nv_idx_ff <= (nv_idx_ff == 3'h4) ? 3'h0 : nv_idx_ff + 3'h1;
               if (nv_idx_ff == 3'h4)
                  nv_st_ff <= NV_IDLE;
            end
            NV_SAVE:
            begin
               // Writes are refused while the store is busy
               nv_mem[nv_idx_ff] <= act_ff[nv_idx_ff];
               nv_idx_ff <= (nv_idx_ff == 3'h4) ? 3'h0 : nv_idx_ff + 3'h1;
               if (nv_idx_ff == 3'h4)
               begin
                  nv_valid <= 1'b1;
                  nv_st_ff <= NV_IDLE;
               end
            end
            NV_IDLE:
            begin
               if (sp_wr && idx_of(sp_addr) != 3'h7)
                  stg_ff[idx_of(sp_addr)] <= sp_wdata;
               if (upd)
               begin
                  // Whole staged set takes effect at once
                  act_ff[0] <= stg_ff[0];
                  act_ff[1] <= stg_ff[1];
                  act_ff[2] <= stg_ff[2];
                  act_ff[3] <= stg_ff[3];
                  act_ff[4] <= stg_ff[4];
               end
               if (sp_wr && sp_addr == `OFS_NV_CTRL && sp_wdata[`NV_STORE_BIT])
                  nv_st_ff <= NV_SAVE;
            end
            default:
               nv_st_ff <= NV_IDLE;
         endcase
      end
   end

   // Calibration starts only on a 0 to 1 change of the active bit, so a
   // second run needs the bit cleared and strobed first
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         cal_st_ff <= CAL_IDLE;
         cal_cnt_ff <= 8'h00;
         cal_prev_ff <= 1'b0;
      end
      else
      begin
         cal_prev_ff <= act_ff[1][`CAL_BIT];
         case (cal_st_ff)
            CAL_IDLE:
               if (act_ff[1][`CAL_BIT] && !cal_prev_ff)
               begin
                  cal_st_ff <= CAL_RUN;
                  cal_cnt_ff <= 8'h00;
               end
            CAL_RUN:
            begin
               cal_cnt_ff <= cal_cnt_ff + 8'h01;
               if (cal_cnt_ff == CAL_LAST)
                  cal_st_ff <= CAL_DONE;
            end
            CAL_DONE:
               if (!act_ff[1][`CAL_BIT])
                  cal_st_ff <= CAL_IDLE;
            default:
               cal_st_ff <= CAL_IDLE;
         endcase
      end
   end

   // Registered outputs from the active set, the serial port and the calibration state
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sdo_ff_o <= 1'b0;
         sdo_oe_o <= 1'b0;
         pll_power_down_ff <= 1'b1;
         vco_source_ff <= 1'b0;
         div_bypass_ff <= 1'b0;
         div_ratio_ff <= 3'h2;
         pd_negative_ff <= 1'b0;
         vco_power_on_ff <= 1'b0;
         ext_to_prescaler_ff <= 1'b0;
         ref_enable_ff <= 3'h0;
         cal_busy_ff <= 1'b0;
         cal_done_ff <= 1'b0;
      end
      else
      begin
         sdo_ff_o <= sp_sdo;
         sdo_oe_o <= sp_oe;
         // Codes other than normal keep the PLL off, the safe side
         pll_power_down_ff <= act_ff[0][`PWR_MSB:`PWR_LSB] != `PWR_NORMAL;
         pd_negative_ff <= act_ff[0][`POL_BIT];
         vco_source_ff <= act_ff[4][`SRC_BIT];
         div_bypass_ff <= act_ff[4][`BYPASS_BIT];
         div_ratio_ff <= ratio_of(act_ff[3][2:0]);
         ref_enable_ff <= act_ff[2][2:0];
         // Internal VCO runs only when selected; otherwise, with the power
         // field normal, the external clock goes straight to the prescaler
         vco_power_on_ff <= act_ff[4][`SRC_BIT];
         ext_to_prescaler_ff <= !act_ff[4][`SRC_BIT]
            && act_ff[0][`PWR_MSB:`PWR_LSB] == `PWR_NORMAL;
         cal_busy_ff <= cal_st_ff == CAL_RUN;
         cal_done_ff <= cal_st_ff == CAL_DONE;
      end
   end
endmodule // clock_path_config

// >>> hdl/clock_path_config_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the clock source path configuration block.
// Assumes a 20 MHz system clock and byte-wide registers on a 13-bit space.
// What this block does
// - Power field 00b runs PLL, 01b powers down
// - Source bit 1b selects VCO, 0b external
// - Bypass bit 0b uses divider, 1b skips it
// - Ratio field sets divider: 1 to 6
// - Polarity bit 0b positive, 1b negative sense
// - Power-up default: PLL off, external via divider
// - Reset restores those same defaults until a set has been saved
// - External oscillator mode: VCO off, feeds prescaler while power field is 00b
// - Settings saved to nonvolatile store, loaded automatically
`ifndef CLOCK_PATH_CONFIG_REGS_VH
`define CLOCK_PATH_CONFIG_REGS_VH

// Register offsets
`define OFS_PWR_POL 13'h010
`define OFS_VCO_CAL 13'h018
`define OFS_REF_EN 13'h01c
`define OFS_STATUS 13'h01f
`define OFS_DIV_RATIO 13'h1e0
`define OFS_SRC_SEL 13'h1e1
`define OFS_UPDATE 13'h232
`define OFS_NV_CTRL 13'hb02

// Field positions
`define PWR_LSB 0
`define PWR_MSB 1
`define POL_BIT 7
`define CAL_BIT 0
`define BYPASS_BIT 0
`define SRC_BIT 1
`define UPDATE_BIT 0
`define NV_STORE_BIT 0

// Power field codes
`define PWR_NORMAL 2'h0
`define PWR_ASYNC_DOWN 2'h1

// Reset values
`define RST_PWR_POL 8'h01
`define RST_VCO_CAL 8'h00
`define RST_REF_EN 8'h00
`define RST_DIV_RATIO 8'h00
`define RST_SRC_SEL 8'h00

// Calibration time and derived count at 20 MHz (50 ns period)
`define CAL_TIME_NS 2000
`define CLK_PERIOD_NS 50
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hdl/serial_port_slave.v
// Serial control port: 16-bit instruction then one data byte, MSB first.
// Assumes sclk, cs_n and sdi are synchronous to sys_clk and much slower.
`timescale 1ns/1ps
module serial_port_slave
(
   input wire sys_clk,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire sdi,
   input wire [7:0] rdata,
   output reg sdo_ff,
   output reg sdo_oe_ff,
   output reg [12:0] addr_ff,
   output reg [7:0] wdata_ff,
   output reg wr_ff
);
   reg sclk_prev_ff; // Last sampled serial clock
   reg [4:0] cnt_ff; // Bits received in this frame
   reg [15:0] sh_ff; // Receive shift register
   reg rd_ff; // Frame is a read
   reg [7:0] tx_ff; // Transmit shift register
   wire rise = sclk & ~sclk_prev_ff;
   wire fall = ~sclk & sclk_prev_ff;

   // Shift in on rising edges, shift out on falling edges
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sclk_prev_ff <= 1'b0;
         cnt_ff <= 5'h00;
         sh_ff <= 16'h0000;
         rd_ff <= 1'b0;
         tx_ff <= 8'h00;
         sdo_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
         addr_ff <= 13'h0000;
         wdata_ff <= 8'h00;
         wr_ff <= 1'b0;
      end
      else
      begin
         sclk_prev_ff <= sclk;
         wr_ff <= 1'b0;
         if (cs_n)
         begin
            // Frame aborted or ended: release the data line
            cnt_ff <= 5'h00;
            sdo_oe_ff <= 1'b0;
         end
         else if (rise && cnt_ff < 5'h18)
         begin
            sh_ff <= {sh_ff[14:0], sdi};
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == 5'h0f)
            begin
               // Instruction complete; latch address, read data is fetched on the next fall
               rd_ff <= sh_ff[14];
               addr_ff <= {sh_ff[11:0], sdi};
            end
            if (cnt_ff == 5'h17 && !rd_ff)
            begin
               wdata_ff <= {sh_ff[6:0], sdi};
               wr_ff <= 1'b1;
            end
         end
         else if (fall && cnt_ff == 5'h10 && rd_ff)
         begin
            // First data bit goes out after the instruction
            tx_ff <= {rdata[6:0], 1'b0};
            sdo_ff <= rdata[7];
            sdo_oe_ff <= 1'b1;
         end
         else if (fall && cnt_ff > 5'h10 && cnt_ff < 5'h18 && rd_ff)
         begin
            sdo_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
         end
         else if (fall && cnt_ff == 5'h18)
         begin
            sdo_oe_ff <= 1'b0;
         end
      end
   end
endmodule // serial_port_slave

// >>> testbench/clock_path_config_properties.sv
// Port-level checks for the clock source path configuration block.
// Assumes one sys_clk domain with a synchronous active-high rst.
`timescale 1ns/1ps
`include "clock_path_config_regs.vh"
module clock_path_config_properties
(
   input wire sys_clk,
   input wire rst,
   input wire cs_n,
   input wire sdo_oe_o,
   input wire pll_power_down_ff,
   input wire vco_source_ff,
   input wire div_bypass_ff,
   input wire [2:0] div_ratio_ff,
   input wire vco_power_on_ff,
   input wire ext_to_prescaler_ff,
   input wire cal_busy_ff,
   input wire cal_done_ff
);
   // Busy cycles of the running calibration; a counter, as 40 is past repetition reach
   reg [7:0] busy_cnt_ff;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Count while busy, clear otherwise
   always @(posedge sys_clk)
   begin
      if (rst || !cal_busy_ff)
         busy_cnt_ff <= 8'h00;
      else
         busy_cnt_ff <= busy_cnt_ff + 8'h01;
   end

   a_vco_follow: assert property (vco_power_on_ff == vco_source_ff)
      else $error("VCO power differs from source select");
   a_ext_route: assert property
      (ext_to_prescaler_ff == (!vco_source_ff && !pll_power_down_ff))
      else $error("External prescaler feed wrong");
   a_ratio_range: assert property (div_ratio_ff >= 3'h1 && div_ratio_ff <= 3'h6)
      else $error("Divider ratio out of range");
   a_reset_dflt: assert property (disable iff (1'b0) rst |=>
      pll_power_down_ff && !vco_source_ff && !div_bypass_ff && div_ratio_ff == 3'h2)
      else $error("Defaults not restored by reset");
   a_busy_excl: assert property (!(cal_busy_ff && cal_done_ff))
      else $error("Busy and done together");
   a_busy_len: assert property ($fell(cal_busy_ff) |->
      (busy_cnt_ff == `CAL_CYCLES) ##[0:1] cal_done_ff)
      else $error("Calibration length or done wrong");
   a_restart_clear: assert property ($rose(cal_busy_ff) |-> !$past(cal_done_ff))
      else $error("Calibration restarted without clear");
   a_oe_idle: assert property (cs_n [*3] |-> !sdo_oe_o)
      else $error("Read driver on while deselected");
endmodule // clock_path_config_properties

bind clock_path_config clock_path_config_properties u_clock_path_config_properties
(
   .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sdo_oe_o(sdo_oe_o),
   .pll_power_down_ff(pll_power_down_ff), .vco_source_ff(vco_source_ff),
   .div_bypass_ff(div_bypass_ff), .div_ratio_ff(div_ratio_ff),
   .vco_power_on_ff(vco_power_on_ff), .ext_to_prescaler_ff(ext_to_prescaler_ff),
   .cal_busy_ff(cal_busy_ff), .cal_done_ff(cal_done_ff)
);

// >>> testbench/clock_path_config_tb.sv
// Self-checking bench for the clock source path configuration block.
// Drives the serial port at sys_clk falling edges; checker is bound separately.
`timescale 1ns/1ps
`include "clock_path_config_regs.vh"
module clock_path_config_tb;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg sclk = 1'b0;
   reg cs_n = 1'b1;
   reg sdi = 1'b0;
   wire sdo_ff_o, sdo_oe_o, pll_power_down_ff, vco_source_ff, div_bypass_ff;
   wire pd_negative_ff, vco_power_on_ff, ext_to_prescaler_ff, cal_busy_ff, cal_done_ff;
   wire [2:0] div_ratio_ff, ref_enable_ff;
   // All configuration outputs in one observed word
   wire [13:0] obs = {ref_enable_ff, pll_power_down_ff, vco_source_ff, div_bypass_ff,
      div_ratio_ff, pd_negative_ff, vco_power_on_ff, ext_to_prescaler_ff,
      cal_busy_ff, cal_done_ff};
   reg [14:0] exp_q[$]; // Notes: bit 14 marks a read byte
   reg [14:0] ent;
   reg chk_req = 1'b0; // Driver flags that a result is ready
   reg [7:0] rd_byte = 8'h00;
   reg [7:0] r8;
   integer seed, err_count, tests_run, k, j, n;

   clock_path_config u_clock_path_config
   (
      .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_ff_o(sdo_ff_o), .sdo_oe_o(sdo_oe_o), .pll_power_down_ff(pll_power_down_ff),
      .vco_source_ff(vco_source_ff), .div_bypass_ff(div_bypass_ff),
      .div_ratio_ff(div_ratio_ff), .pd_negative_ff(pd_negative_ff),
      .vco_power_on_ff(vco_power_on_ff), .ext_to_prescaler_ff(ext_to_prescaler_ff),
      .ref_enable_ff(ref_enable_ff), .cal_busy_ff(cal_busy_ff), .cal_done_ff(cal_done_ff)
   );

   // 50 ns period
   always #25 sys_clk = ~sys_clk;

   task check(input [13:0] got, input [13:0] want);
   begin
      tests_run = tests_run + 1;
      if (got !== want)
      begin
         err_count = err_count + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
   end
   endtask

   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask

   // Expected outputs; ratio codes above 4 divide by one
   function [13:0] cfg(input [2:0] rf, input [3:0] m, input [2:0] code, input [1:0] cal);
      reg [2:0] r;
   begin
      r = (code < 3'h5) ? code + 3'h2 : 3'h1;
      cfg = {rf, m[3], m[2], m[1], r, m[0], m[2], ~m[2] & ~m[3], cal};
   end
   endfunction

   // Queue a note, then flag the watcher for one cycle
   task note_exp(input kd, input [13:0] v);
   begin
      exp_q.push_back({kd, v});
      chk_req = 1'b1;
      @(negedge sys_clk);
      chk_req = 1'b0;
   end
   endtask

   // One frame: 24 bits MSB first, half period 4 sys_clk for margin over the 2 minimum
   task xfer(input rw, input [12:0] a, input [7:0] d);
      integer i;
      reg [23:0] w;
   begin
      w = {rw, 2'b00, a, d};
      cs_n = 1'b0;
      for (i = 23; i >= 0; i = i - 1)
      begin
         sdi = w[i];
         repeat (4) @(negedge sys_clk);
         if (i < 8)
            rd_byte[i] = sdo_ff_o; // Read bit has settled since the last fall
         sclk = 1'b1;
         repeat (4) @(negedge sys_clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge sys_clk);
      cs_n = 1'b1;
      sdi = $random(seed); // Idle line carries noise, not the last bit
      repeat (4) @(negedge sys_clk);
   end
   endtask

   task commit;
      xfer(1'b0, `OFS_UPDATE, 8'h01);
   endtask

   // Reset, then let the store load finish before any frame
   task do_reset;
   begin
      rst = 1'b1;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (10) @(negedge sys_clk);
   end
   endtask

   // Watcher: oldest note against what the outputs show now
   always @(posedge sys_clk)
   begin
      if (chk_req && exp_q.size() > 0)
      begin
         ent = exp_q.pop_front();
         check(ent[14] ? {6'h00, rd_byte} : obs, ent[13:0]);
      end
   end

   initial
   begin
      seed = 25643;
      err_count = 0;
      tests_run = 0;
      do_reset;
      note_exp(1'b0, cfg(3'h0, 4'h8, 3'h0, 2'h0));
      xfer(1'b1, `OFS_PWR_POL, 8'h00);
      note_exp(1'b1, {6'h00, `RST_PWR_POL});
      xfer(1'b1, 13'h123, 8'h00);
      note_exp(1'b1, 14'h0000);
      xfer(1'b0, `OFS_SRC_SEL, 8'h02);
      note_exp(1'b0, cfg(3'h0, 4'h8, 3'h0, 2'h0));
      xfer(1'b1, `OFS_SRC_SEL, 8'h00);
      note_exp(1'b1, 14'h0002);
      commit;
      note_exp(1'b0, cfg(3'h0, 4'hc, 3'h0, 2'h0));
      // Every ratio code with random power, bypass, polarity and reference enables
      for (k = 0; k < 8; k = k + 1)
      begin
         r8 = $random(seed);
         xfer(1'b0, `OFS_DIV_RATIO, {5'h00, k[2:0]});
         // Source stays external here, so only the clock input may skip the divider
         xfer(1'b0, `OFS_SRC_SEL, {7'h00, r8[0]});
         xfer(1'b0, `OFS_PWR_POL, {r8[7], 6'h00, r8[1]});
         xfer(1'b0, `OFS_REF_EN, {5'h00, r8[4:2]});
         commit;
         note_exp(1'b0, cfg(r8[4:2], {r8[1], 1'b0, r8[0], r8[7]}, k[2:0], 2'h0));
      end
      do_reset;
      note_exp(1'b0, cfg(3'h0, 4'h8, 3'h0, 2'h0));
      // Internal VCO selected with the divider kept in the path
      xfer(1'b0, `OFS_SRC_SEL, 8'h02);
      // Two calibrations; the second needs the clear first
      for (j = 0; j < 2; j = j + 1)
      begin
         xfer(1'b0, `OFS_VCO_CAL, 8'h01);
         commit;
         n = 0;
         while (!cal_done_ff && n < 200)
         begin
            @(negedge sys_clk);
            n = n + 1;
         end
         if (n == 200)
         begin
            err_count = err_count + 1;
            conclude;
         end
         note_exp(1'b0, cfg(3'h0, 4'hc, 3'h0, 2'h1));
         commit;
         note_exp(1'b0, cfg(3'h0, 4'hc, 3'h0, 2'h1));
         xfer(1'b0, `OFS_VCO_CAL, 8'h00);
         commit;
         note_exp(1'b0, cfg(3'h0, 4'hc, 3'h0, 2'h0));
      end
      // Save a set, change it, then reset and expect the saved set back
      xfer(1'b0, `OFS_SRC_SEL, 8'h00);
      xfer(1'b0, `OFS_PWR_POL, 8'h80);
      xfer(1'b0, `OFS_DIV_RATIO, 8'h03);
      xfer(1'b0, `OFS_REF_EN, 8'h05);
      commit;
      xfer(1'b0, `OFS_NV_CTRL, 8'h01);
      repeat (10) @(negedge sys_clk);
      xfer(1'b0, `OFS_SRC_SEL, 8'h02);
      commit;
      do_reset;
      note_exp(1'b0, cfg(3'h5, 4'h1, 3'h3, 2'h0));
      repeat (4) @(negedge sys_clk);
      conclude;
   end
endmodule // clock_path_config_tb
